// File: ntr_pkg.sv
// Package for the target reset and identification state machine.
// Assumes a single 40 MHz clock domain; used by ntr_fsm and ntr_sig_rom.
package ntr_pkg;
  // ----------------------------------------
  // Command and address codes
  // ----------------------------------------
  localparam logic [7:0] CMD_RESET      = 8'hFF;
  localparam logic [7:0] CMD_SYNC_RESET = 8'hFC;
  localparam logic [7:0] CMD_READ_ID    = 8'h90;
  localparam logic [7:0] CMD_READ_STAT  = 8'h70;
  localparam logic [7:0] ADDR_ID_STD    = 8'h00;
  localparam logic [7:0] ADDR_ID_SIG    = 8'h20;

  // ----------------------------------------
  // Reset values and signature layout
  // ----------------------------------------
  localparam logic [7:0] LAST_CMD_RST   = 8'hFF;
  localparam int         SIG_BYTES      = 4;
  localparam logic [31:0] SIG_WORD      = 32'h5C3B_2A19; // Arbitrary value, low byte first
  localparam logic [7:0] MFR_CODE_DEF   = 8'h5A; // Arbitrary value
  localparam logic [7:0] DEV_CODE_DEF   = 8'hA5; // Arbitrary value

  // ----------------------------------------
  // Target states
  // ----------------------------------------
  typedef enum logic [3:0] {
    NTR_PWR_ON,
    NTR_PWR_ON_EXEC,
    NTR_RST_EXEC,
    NTR_RST_SYNC,
    NTR_RST_PERFORM,
    NTR_RST_END,
    NTR_IDLE,
    NTR_IDLE_RD,
    NTR_IDLE_RD_STATUS,
    NTR_STATUS_READ_EXECUTE_STATE,
    NTR_CMD_DECODE,
    NTR_RID_EXEC,
    NTR_RID_WAIT_STD,
    NTR_RID_MFR,
    NTR_RID_WAIT_SIG
  } ntr_state_t;
endpackage : ntr_pkg

// File: ntr_sig_rom.sv
// Signature byte store with registered read data.
// Assumes the reader presents an index and samples data one cycle later.
`timescale 1ns/10ps
module ntr_sig_rom #(
  parameter int DEPTH = ntr_pkg::SIG_BYTES
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       rd_en,
  input  wire logic [1:0] rd_idx,
  output logic      [7:0] rd_data
);
  // ----------------------------------------
  // Registered lookup
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      rd_data <= ntr_pkg::SIG_WORD[{rd_idx, 3'b000} +: 8];
    end
  end
endmodule : ntr_sig_rom

// File: ntr_fsm.sv
// Target level reset and identification command state machine.
// Assumes command, address and read strobes are one-cycle pulses synchronous to clk.
`timescale 1ns/10ps
// Operation
// - First reset: last command FFh, status flag clear, reset LUNs, busy.
// - FFh reset: last command FFh, async interface, reset LUNs, clear flags, invalidate.
// - FCh reset: last command FCh, status flag clear, reset LUNs, clear flags, invalidate.
// - During reset hold busy and set resume state to reset-perform.
// - Read status command during reset goes to status read execution.
// - Read request during reset with status flag set enters idle status read.
// - Reset done: ready high, then idle or idle-read by status flag.
// - 90h: last command 90h, clear flags, invalidate pages, await address.
// - Address 00h: maker code, then device code, then idle-read.
// - Address 20h: next signature byte per read, idle-read after last.
module ntr_fsm #(
  parameter logic [7:0] MFR_CODE = ntr_pkg::MFR_CODE_DEF,
  parameter logic [7:0] DEV_CODE = ntr_pkg::DEV_CODE_DEF
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             cmd_valid,
  input  wire logic [7:0]       cmd_code,
  input  wire logic             addr_valid,
  input  wire logic [7:0]       addr_byte,
  input  wire logic             rd_req,
  input  wire logic             reset_done,
  input  wire logic             status_out_set,
  output logic                  ready_busy_n,
  output logic [7:0]            last_command_code,
  output logic                  status_output_flag,
  output logic                  column_change_allowed,
  output logic                  enhanced_column_change_allowed,
  output logic                  async_if_select,
  output logic                  lun_reset_req,
  output logic                  lun_invalidate_req,
  output logic                  status_read_req,
  output logic [7:0]            rd_data,
  output logic                  rd_data_valid,
  output ntr_pkg::ntr_state_t   state,
  output ntr_pkg::ntr_state_t   resume_state
);
  // ----------------------------------------
  // State storage
  // ----------------------------------------
  ntr_pkg::ntr_state_t state_r;
  ntr_pkg::ntr_state_t state_nxt;
  ntr_pkg::ntr_state_t resume_r;
  logic                first_rst_r;
  logic [1:0]          sig_idx_r;
  logic [7:0]          id_byte_r;
  logic                id_sel_sig_r;
  logic                rd_pulse_r;
  logic [7:0]          sig_byte;
  logic                sig_rd;
  logic [7:0]          cmd_code_r;

  assign state        = state_r;
  assign resume_state = resume_r;

  // Reset commands are honoured in any state
  function automatic logic is_reset(input logic v, input logic [7:0] c);
    is_reset = v && (c == ntr_pkg::CMD_RESET || c == ntr_pkg::CMD_SYNC_RESET);
  endfunction : is_reset

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ntr_pkg::NTR_PWR_ON:      state_nxt = ntr_pkg::NTR_PWR_ON_EXEC;
      ntr_pkg::NTR_PWR_ON_EXEC: state_nxt = ntr_pkg::NTR_RST_PERFORM;
      ntr_pkg::NTR_RST_EXEC,
      ntr_pkg::NTR_RST_SYNC:    state_nxt = ntr_pkg::NTR_RST_PERFORM;
      ntr_pkg::NTR_RST_PERFORM: begin
        if (reset_done) begin
          state_nxt = ntr_pkg::NTR_RST_END;
        end else if (cmd_valid && cmd_code == ntr_pkg::CMD_READ_STAT) begin
          state_nxt = ntr_pkg::NTR_STATUS_READ_EXECUTE_STATE;
        end else if (rd_req && status_output_flag) begin
          state_nxt = ntr_pkg::NTR_IDLE_RD_STATUS;
        end
      end
      ntr_pkg::NTR_RST_END: begin
        state_nxt = status_output_flag ? ntr_pkg::NTR_IDLE_RD : ntr_pkg::NTR_IDLE;
      end
      ntr_pkg::NTR_CMD_DECODE: begin
        if (cmd_code_r == ntr_pkg::CMD_READ_ID) begin
          state_nxt = ntr_pkg::NTR_RID_EXEC;
        end else begin
          state_nxt = ntr_pkg::NTR_IDLE;
        end
      end
      ntr_pkg::NTR_RID_EXEC: begin
        if (addr_valid && addr_byte == ntr_pkg::ADDR_ID_STD) begin
          state_nxt = ntr_pkg::NTR_RID_WAIT_STD;
        end else if (addr_valid && addr_byte == ntr_pkg::ADDR_ID_SIG) begin
          state_nxt = ntr_pkg::NTR_RID_WAIT_SIG;
        end
      end
      ntr_pkg::NTR_RID_WAIT_STD: begin
        if (rd_req) begin
          state_nxt = ntr_pkg::NTR_RID_MFR;
        end else if (cmd_valid) begin
          state_nxt = ntr_pkg::NTR_CMD_DECODE;
        end
      end
      ntr_pkg::NTR_RID_MFR: begin
        if (rd_req) begin
          state_nxt = ntr_pkg::NTR_IDLE_RD;
        end else if (cmd_valid) begin
          state_nxt = ntr_pkg::NTR_CMD_DECODE;
        end
      end
      ntr_pkg::NTR_RID_WAIT_SIG: begin
        if (rd_req && sig_idx_r == 2'(ntr_pkg::SIG_BYTES - 1)) begin
          state_nxt = ntr_pkg::NTR_IDLE_RD;
        end else if (rd_req) begin
          state_nxt = ntr_pkg::NTR_RID_WAIT_SIG;
        end else if (cmd_valid) begin
          state_nxt = ntr_pkg::NTR_CMD_DECODE;
        end
      end
      default: begin
        if (cmd_valid) begin
          state_nxt = ntr_pkg::NTR_CMD_DECODE;
        end
      end
    endcase
    // Reset commands override everything
    if (is_reset(cmd_valid, cmd_code)) begin
      if (cmd_code == ntr_pkg::CMD_SYNC_RESET) begin
        state_nxt = ntr_pkg::NTR_RST_SYNC;
      end else if (first_rst_r) begin
        state_nxt = ntr_pkg::NTR_PWR_ON;
      end else begin
        state_nxt = ntr_pkg::NTR_RST_EXEC;
      end
    end
  end

  // ----------------------------------------
  // State and resume registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r  <= ntr_pkg::NTR_PWR_ON;
      resume_r <= ntr_pkg::NTR_IDLE;
    end else begin
      state_r <= state_nxt;
      if (state_r == ntr_pkg::NTR_RST_PERFORM) begin
        resume_r <= ntr_pkg::NTR_RST_PERFORM;
      end
    end
  end

  // Command code captured with its strobe; the bus is not held during decode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_code_r <= 8'h00;
    end else if (cmd_valid) begin
      cmd_code_r <= cmd_code;
    end
  end

  // First reset after power-on pending
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      first_rst_r <= 1'b1;
    end else if (state_r == ntr_pkg::NTR_PWR_ON) begin
      first_rst_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Target attributes
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_command_code              <= ntr_pkg::LAST_CMD_RST;
      status_output_flag             <= 1'b0;
      column_change_allowed          <= 1'b0;
      enhanced_column_change_allowed <= 1'b0;
      async_if_select                <= 1'b1;
    end else begin
      // Status flag set by status handling wins over clear
      if (status_out_set) begin
        status_output_flag <= 1'b1;
      end
      case (state_r)
        ntr_pkg::NTR_PWR_ON: begin
          last_command_code <= ntr_pkg::CMD_RESET;
          if (!status_out_set) begin
            status_output_flag <= 1'b0;
          end
        end
        ntr_pkg::NTR_RST_EXEC: begin
          last_command_code              <= ntr_pkg::CMD_RESET;
          async_if_select                <= 1'b1;
          column_change_allowed          <= 1'b0;
          enhanced_column_change_allowed <= 1'b0;
        end
        ntr_pkg::NTR_RST_SYNC: begin
          last_command_code              <= ntr_pkg::CMD_SYNC_RESET;
          column_change_allowed          <= 1'b0;
          enhanced_column_change_allowed <= 1'b0;
          if (!status_out_set) begin
            status_output_flag <= 1'b0;
          end
        end
        ntr_pkg::NTR_RID_EXEC: begin
          last_command_code              <= ntr_pkg::CMD_READ_ID;
          column_change_allowed          <= 1'b0;
          enhanced_column_change_allowed <= 1'b0;
        end
        default: begin
          last_command_code <= last_command_code;
        end
      endcase
    end
  end

  // ----------------------------------------
  // LUN requests and ready/busy
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lun_reset_req      <= 1'b0;
      lun_invalidate_req <= 1'b0;
      status_read_req    <= 1'b0;
      ready_busy_n       <= 1'b0;
    end else begin
      // Leaving power-on also covers the pass that starts from nrst
      lun_reset_req      <= (state_r == ntr_pkg::NTR_PWR_ON) || (state_nxt == ntr_pkg::NTR_RST_EXEC)
                            || (state_nxt == ntr_pkg::NTR_RST_SYNC);
      lun_invalidate_req <= (state_nxt == ntr_pkg::NTR_RST_EXEC) || (state_nxt == ntr_pkg::NTR_RST_SYNC)
                            || (state_nxt == ntr_pkg::NTR_RID_EXEC && state_r != ntr_pkg::NTR_RID_EXEC);
      status_read_req    <= (state_nxt == ntr_pkg::NTR_STATUS_READ_EXECUTE_STATE) ||
                            (state_nxt == ntr_pkg::NTR_IDLE_RD_STATUS);
      if (state_r == ntr_pkg::NTR_PWR_ON_EXEC || state_r == ntr_pkg::NTR_RST_PERFORM
          || state_r == ntr_pkg::NTR_RST_EXEC || state_r == ntr_pkg::NTR_RST_SYNC) begin
        ready_busy_n <= 1'b0;
      end else if (state_r == ntr_pkg::NTR_RST_END) begin
        ready_busy_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Identification data path
  // ----------------------------------------
  assign sig_rd = (state_r == ntr_pkg::NTR_RID_WAIT_SIG) && rd_req;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sig_idx_r    <= 2'b00;
      id_byte_r    <= 8'h00;
      id_sel_sig_r <= 1'b0;
      rd_pulse_r   <= 1'b0;
    end else begin
      rd_pulse_r   <= 1'b0;
      if (state_r == ntr_pkg::NTR_RID_EXEC) begin
        sig_idx_r <= 2'b00;
      end
      // Source select holds so read data stands until the next read
      if (rd_req && state_r == ntr_pkg::NTR_RID_WAIT_STD) begin
        id_byte_r    <= MFR_CODE;
        id_sel_sig_r <= 1'b0;
        rd_pulse_r   <= 1'b1;
      end else if (rd_req && state_r == ntr_pkg::NTR_RID_MFR) begin
        id_byte_r    <= DEV_CODE;
        id_sel_sig_r <= 1'b0;
        rd_pulse_r   <= 1'b1;
      end else if (sig_rd) begin
        sig_idx_r    <= sig_idx_r + 2'b01;
        id_sel_sig_r <= 1'b1;
        rd_pulse_r   <= 1'b1;
      end
    end
  end

  // Signature store
  ntr_sig_rom u_sig_rom (
    .clk     (clk),
    .nrst    (nrst),
    .rd_en   (sig_rd),
    .rd_idx  (sig_idx_r),
    .rd_data (sig_byte)
  );

  assign rd_data       = id_sel_sig_r ? sig_byte : id_byte_r;
  assign rd_data_valid = rd_pulse_r;
endmodule : ntr_fsm

// File: ntr_fsm_checker.sv
// Assertions on the target reset and identification FSM.
// Sees only ntr_fsm ports; bound at the foot of this file.
`timescale 1ns/10ps
module ntr_fsm_checker (
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic                cmd_valid,
  input wire logic [7:0]          cmd_code,
  input wire logic                rd_req,
  input wire logic                reset_done,
  input wire logic                ready_busy_n,
  input wire logic [7:0]          last_command_code,
  input wire logic                status_output_flag,
  input wire logic                column_change_allowed,
  input wire logic                async_if_select,
  input wire logic                lun_reset_req,
  input wire logic                lun_invalidate_req,
  input wire ntr_pkg::ntr_state_t state,
  input wire ntr_pkg::ntr_state_t resume_state
);
  // ------
  // Checks
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Reset being performed
  wire perf = state == ntr_pkg::NTR_RST_PERFORM;
  property p_ffh;
    cmd_valid && cmd_code == 8'hFF |-> ##[1:2] (lun_reset_req && lun_invalidate_req) ##[0:2] (last_command_code == 8'hFF && async_if_select && !column_change_allowed);
  endproperty
  a_ffh: assert property (p_ffh) else $error("FFh reset effects missing");
  property p_fch;
    cmd_valid && cmd_code == 8'hFC |-> ##[1:2] (lun_reset_req && lun_invalidate_req) ##[0:2] (last_command_code == 8'hFC && !status_output_flag && !column_change_allowed);
  endproperty
  a_fch: assert property (p_fch) else $error("FCh reset effects missing");
  property p_perf;
    perf ##1 perf |-> !ready_busy_n && resume_state == ntr_pkg::NTR_RST_PERFORM;
  endproperty
  a_perf: assert property (p_perf) else $error("busy or resume state wrong in reset");
  property p_rs;
    perf && cmd_valid && cmd_code == 8'h70 |-> ##[1:2] state == ntr_pkg::NTR_STATUS_READ_EXECUTE_STATE;
  endproperty
  a_rs: assert property (p_rs) else $error("70h in reset not taken");
  property p_rds;
    perf && rd_req && status_output_flag && !cmd_valid && !reset_done |-> ##[1:2] state == ntr_pkg::NTR_IDLE_RD_STATUS;
  endproperty
  a_rds: assert property (p_rds) else $error("read in reset not taken");
  property p_end;
    perf && reset_done && !cmd_valid && !rd_req |-> ##[1:3] (ready_busy_n && state == (status_output_flag ? ntr_pkg::NTR_IDLE_RD : ntr_pkg::NTR_IDLE));
  endproperty
  a_end: assert property (p_end) else $error("reset end wrong");
  property p_rid;
    cmd_valid && cmd_code == 8'h90 && state inside {ntr_pkg::NTR_IDLE, ntr_pkg::NTR_IDLE_RD} |-> ##[1:3] (lun_invalidate_req && !column_change_allowed) ##[0:2] last_command_code == 8'h90;
  endproperty
  a_rid: assert property (p_rid) else $error("90h effects missing");
  property p_abn;
    cmd_valid && cmd_code == 8'h90 && state inside {ntr_pkg::NTR_RID_WAIT_STD, ntr_pkg::NTR_RID_MFR, ntr_pkg::NTR_RID_WAIT_SIG} |=> state == ntr_pkg::NTR_CMD_DECODE;
  endproperty
  a_abn: assert property (p_abn) else $error("command did not abandon read");
  property p_pwr;
    state == ntr_pkg::NTR_PWR_ON |=> lun_reset_req;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-on LUN reset missing");
  c_rs: cover property (state == ntr_pkg::NTR_STATUS_READ_EXECUTE_STATE);
  c_rds: cover property (state == ntr_pkg::NTR_IDLE_RD_STATUS);
  c_end: cover property (perf && reset_done);
endmodule : ntr_fsm_checker
bind ntr_fsm ntr_fsm_checker u_chk (.clk, .nrst, .cmd_valid, .cmd_code, .rd_req, .reset_done, .ready_busy_n,
  .last_command_code, .status_output_flag, .column_change_allowed, .async_if_select, .lun_reset_req,
  .lun_invalidate_req, .state, .resume_state);

// File: ntr_host_model.sv
// Host controller model driving command, address and read strobes.
// Assumes the bench clock; strobes change on the falling edge.
`timescale 1ns/10ps
module ntr_host_model (
  input  wire logic  clk,
  output logic       cmd_valid = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic       addr_valid = 1'b0,
  output logic [7:0] addr_byte = 8'h00,
  output logic       rd_req = 1'b0
);
  // ------------
  // Strobe tasks
  // ------------
  // One command or address cycle; released lines show the inverse
  task automatic strobe(input bit is_addr, input logic [7:0] v);
    @(negedge clk);
    if (is_addr) begin
      addr_byte = v;
      addr_valid = 1'b1;
    end else begin
      cmd_code = v;
      cmd_valid = 1'b1;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    addr_valid = 1'b0;
    cmd_code = ~cmd_code;
    addr_byte = ~addr_byte;
  endtask : strobe
  // One read request; caller bounds the count per path
  task automatic read_byte();
    @(negedge clk);
    rd_req = 1'b1;
    @(negedge clk);
    rd_req = 1'b0;
  endtask : read_byte
endmodule : ntr_host_model

// File: test_nand_target_reset_and_id_fsm.sv
// Self-checking bench for the target reset and identification FSM.
// Assumes the host model and the bound checker compile alongside.
`timescale 1ns/10ps
module test_nand_target_reset_and_id_fsm;
  typedef struct packed {logic [7:0] addr; logic [2:0] n; logic [31:0] bytes;} ntr_row_t;
  logic                clk, nrst, reset_done, status_out_set, cmd_valid, addr_valid, rd_req, ready_busy_n;
  logic                status_output_flag, column_change_allowed, enhanced_column_change_allowed, async_if_select;
  logic                lun_reset_req, lun_invalidate_req, status_read_req, rd_data_valid;
  logic [7:0]          cmd_code, addr_byte, last_command_code, rd_data;
  ntr_pkg::ntr_state_t state, resume_state;
  ntr_row_t            rows [2];
  int                  mismatches, cmp_count;
  // -----------------------
  // Design, host and clock
  // -----------------------
  ntr_fsm DUT (.clk, .nrst, .cmd_valid, .cmd_code, .addr_valid, .addr_byte, .rd_req, .reset_done,
    .status_out_set, .ready_busy_n, .last_command_code, .status_output_flag, .column_change_allowed,
    .enhanced_column_change_allowed, .async_if_select, .lun_reset_req, .lun_invalidate_req, .status_read_req,
    .rd_data, .rd_data_valid, .state, .resume_state);
  ntr_host_model host (.clk, .cmd_valid, .cmd_code, .addr_valid, .addr_byte, .rd_req);
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Bounded wait for a state
  task automatic wait_state(input ntr_pkg::ntr_state_t e);
    int n;
    n = 0;
    while (state !== e && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("state", {4'h0, e}, {4'h0, state});
  endtask : wait_state
  // One-cycle pulse of reset_done or status_out_set
  task automatic pulse(input bit s);
    @(negedge clk);
    reset_done = s;
    status_out_set = !s;
    @(negedge clk);
    reset_done = 1'b0;
    status_out_set = 1'b0;
  endtask : pulse
  // Verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // Watchdog
  initial begin
    #(25 * 3000);
    mismatches++;
    complete_run();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    reset_done = 1'b0;
    status_out_set = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    rows[0] = {ntr_pkg::ADDR_ID_STD, 3'h2, 16'h0000, ntr_pkg::DEV_CODE_DEF, ntr_pkg::MFR_CODE_DEF};
    rows[1] = {ntr_pkg::ADDR_ID_SIG, 3'h4, ntr_pkg::SIG_WORD};
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("rdy", 8'h00, {7'h00, ready_busy_n});
    chk("last", 8'hFF, last_command_code);
    chk("flag", 8'h00, {7'h00, status_output_flag});
    nrst = 1'b1;
    @(negedge clk);
    chk("lunrst", 8'h01, {7'h00, lun_reset_req});
    wait_state(ntr_pkg::NTR_RST_PERFORM);
    pulse(1'b1);
    wait_state(ntr_pkg::NTR_IDLE);
    chk("rdy", 8'h01, {7'h00, ready_busy_n});
    for (int r = 0; r < 2; r++) begin
      host.strobe(1'b0, ntr_pkg::CMD_READ_ID);
      wait_state(ntr_pkg::NTR_RID_EXEC);
      host.strobe(1'b1, rows[r].addr);
      chk("last", ntr_pkg::CMD_READ_ID, last_command_code);
      for (int b = 0; b < int'(rows[r].n); b++) begin
        host.read_byte();
        chk("valid", 8'h01, {7'h00, rd_data_valid});
        chk("data", rows[r].bytes[8*b +: 8], rd_data);
      end
      chk("state", {4'h0, ntr_pkg::NTR_IDLE_RD}, {4'h0, state});
      @(negedge clk);
      chk("valid", 8'h00, {7'h00, rd_data_valid});
      chk("hold", rows[r].bytes[8*(int'(rows[r].n)-1) +: 8], rd_data);
    end
    pulse(1'b0);
    host.strobe(1'b0, ntr_pkg::CMD_SYNC_RESET);
    chk("lunrst", 8'h01, {7'h00, lun_reset_req});
    chk("inval", 8'h01, {7'h00, lun_invalidate_req});
    wait_state(ntr_pkg::NTR_RST_PERFORM);
    @(negedge clk);
    chk("last", 8'hFC, last_command_code);
    chk("flag", 8'h00, {7'h00, status_output_flag});
    chk("rdy", 8'h00, {7'h00, ready_busy_n});
    chk("resume", {4'h0, ntr_pkg::NTR_RST_PERFORM}, {4'h0, resume_state});
    host.strobe(1'b0, ntr_pkg::CMD_READ_STAT);
    chk("srreq", 8'h01, {7'h00, status_read_req});
    wait_state(ntr_pkg::NTR_STATUS_READ_EXECUTE_STATE);
    host.strobe(1'b0, ntr_pkg::CMD_RESET);
    wait_state(ntr_pkg::NTR_RST_PERFORM);
    chk("last", 8'hFF, last_command_code);
    chk("async", 8'h01, {7'h00, async_if_select});
    chk("ecol", 8'h00, {7'h00, enhanced_column_change_allowed});
    pulse(1'b0);
    pulse(1'b1);
    wait_state(ntr_pkg::NTR_IDLE_RD);
    host.strobe(1'b0, ntr_pkg::CMD_RESET);
    wait_state(ntr_pkg::NTR_RST_PERFORM);
    pulse(1'b0);
    host.read_byte();
    chk("srreq", 8'h01, {7'h00, status_read_req});
    wait_state(ntr_pkg::NTR_IDLE_RD_STATUS);
    host.strobe(1'b0, ntr_pkg::CMD_SYNC_RESET);
    wait_state(ntr_pkg::NTR_RST_PERFORM);
    pulse(1'b1);
    wait_state(ntr_pkg::NTR_IDLE);
    host.strobe(1'b0, ntr_pkg::CMD_READ_ID);
    wait_state(ntr_pkg::NTR_RID_EXEC);
    host.strobe(1'b1, ntr_pkg::ADDR_ID_STD);
    host.read_byte();
    host.strobe(1'b0, ntr_pkg::CMD_READ_ID);
    chk("state", {4'h0, ntr_pkg::NTR_CMD_DECODE}, {4'h0, state});
    wait_state(ntr_pkg::NTR_RID_EXEC);
    host.strobe(1'b1, ntr_pkg::ADDR_ID_SIG);
    host.strobe(1'b0, ntr_pkg::CMD_READ_ID);
    chk("state", {4'h0, ntr_pkg::NTR_CMD_DECODE}, {4'h0, state});
    complete_run();
  end
endmodule : test_nand_target_reset_and_id_fsm
